// File: pkg/ltc_pkg.sv
// Constants, field layouts and types shared by the legacy timer block.
package ltc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int M0_LOW_W = 5;
  localparam int M0_W = 13;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_T01_CTRL = 10'h088;
  localparam logic [IDX_W-1:0] IDX_T01_MODE = 10'h089;
  localparam logic [IDX_W-1:0] IDX_T0_LOW = 10'h08a;
  localparam logic [IDX_W-1:0] IDX_T1_LOW = 10'h08b;
  localparam logic [IDX_W-1:0] IDX_T0_HIGH = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_T1_HIGH = 10'h08d;
  localparam logic [IDX_W-1:0] IDX_T2_CTRL = 10'h0c8;
  localparam logic [IDX_W-1:0] IDX_T2_MODE = 10'h0c9;
  localparam logic [IDX_W-1:0] IDX_RELOAD_LOW = 10'h0ca;
  localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH = 10'h0cb;
  localparam logic [IDX_W-1:0] IDX_T2_COUNT_LOW = 10'h0cc;
  localparam logic [IDX_W-1:0] IDX_T2_COUNT_HIGH = 10'h0cd;
  localparam logic [IDX_W-1:0] IDX_CAP1_LOW = 10'h0ce;
  localparam logic [IDX_W-1:0] IDX_CAP1_HIGH = 10'h0cf;

  // Timer 0/1 control register bit positions.
  localparam int T01C_OVF1 = 7;
  localparam int T01C_RUN1 = 6;
  localparam int T01C_OVF0 = 5;
  localparam int T01C_RUN0 = 4;
  // Timer 2 mode register bit position.
  localparam int T2M_CAP1_EN = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;

  // Pin vector positions.
  localparam int NUM_PINS = 6;
  localparam int PIN_T0_COUNT = 0;
  localparam int PIN_T1_COUNT = 1;
  localparam int PIN_INT0 = 2;
  localparam int PIN_EXTERNAL_INTERRUPT_ONE_PIN = 3;
  localparam int PIN_T2_COUNT = 4;
  localparam int PIN_EXT_TRIG = 5;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_8RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } ltc_mode_e;

  typedef struct packed {
    logic gate_enable;
    logic counter_mode;
    ltc_mode_e mode;
  } ltc_tmode_s;

  typedef struct packed {
    logic flag7;
    logic external_trigger_flag;
    logic uart_rx_baud_select;
    logic uart_tx_baud_select;
    logic external_trigger_enable;
    logic timer2_run;
    logic timer2_clock_source;
    logic capture_reload_select;
  } ltc_t2ctl_s;

  localparam ltc_tmode_s TMODE_RESET = '{1'b0, 1'b0, MODE_13BIT};
  localparam ltc_t2ctl_s T2CTL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage : ltc_pkg

// File: src/ltc_pin_edge.sv
// Two-stage synchroniser with edge detection for one external pin.
`timescale 1ns/1ps
module ltc_pin_edge (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin and results
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Only sync_q reads meta_q; edges compare the two settled samples.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_fall = prev_q & ~sync_q;

endmodule : ltc_pin_edge

// File: src/ltc_top.sv
// Timers 0, 1 and 2 with capture, behind an AXI4-Lite register slave.
`timescale 1ns/1ps
module ltc_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // AXI4-Lite write address and data
  input wire logic [ltc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [ltc_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic [ltc_pkg::STRB_W-1:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // AXI4-Lite read
  input wire logic [ltc_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [ltc_pkg::DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // External pins
  input wire logic I_TIMER0_COUNT_PIN,
  input wire logic I_TIMER1_COUNT_PIN,
  input wire logic I_EXTERNAL_INTERRUPT_ZERO_PIN,
  input wire logic I_EXTERNAL_INTERRUPT_ONE_PIN,
  input wire logic I_TIMER2_COUNT_PIN,
  input wire logic I_EXTERNAL_TRIGGER_PIN,
  // Baud ticks to the first serial port
  output logic O_UART_RX_BAUD_TICK,
  output logic O_UART_TX_BAUD_TICK
);

  localparam int BW = ltc_pkg::BYTE_W;

  // Pin synchronisers.
  logic [ltc_pkg::NUM_PINS-1:0] pins;
  logic [ltc_pkg::NUM_PINS-1:0] pin_level;
  logic [ltc_pkg::NUM_PINS-1:0] pin_fall;

  assign pins[ltc_pkg::PIN_T0_COUNT] = I_TIMER0_COUNT_PIN;
  assign pins[ltc_pkg::PIN_T1_COUNT] = I_TIMER1_COUNT_PIN;
  assign pins[ltc_pkg::PIN_INT0] = I_EXTERNAL_INTERRUPT_ZERO_PIN;
  assign pins[ltc_pkg::PIN_EXTERNAL_INTERRUPT_ONE_PIN] = I_EXTERNAL_INTERRUPT_ONE_PIN;
  assign pins[ltc_pkg::PIN_T2_COUNT] = I_TIMER2_COUNT_PIN;
  assign pins[ltc_pkg::PIN_EXT_TRIG] = I_EXTERNAL_TRIGGER_PIN;

  for (genvar g = 0; g < ltc_pkg::NUM_PINS; g++) begin : g_pin
    ltc_pin_edge u_edge (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RSTN),
      .i_pin(pins[g]),
      .o_level(pin_level[g]),
      .o_fall(pin_fall[g])
    );
  end

  // Bus state.
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [ltc_pkg::DATA_W-1:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [ltc_pkg::STRB_W-1:0] wstrb_q, wstrb_d;
  logic [ltc_pkg::IDX_W-1:0] widx_q, widx_d;

  // Timer state.
  ltc_pkg::ltc_tmode_s tmode0_q, tmode0_d, tmode1_q, tmode1_d;
  ltc_pkg::ltc_t2ctl_s t2ctl_q, t2ctl_d;
  logic run0_q, run0_d, run1_q, run1_d, ovf0_q, ovf0_d, ovf1_q, ovf1_d;
  logic cap1_en_q, cap1_en_d;
  logic [BW-1:0] lo0_q, lo0_d, hi0_q, hi0_d, lo1_q, lo1_d, hi1_q, hi1_d;
  logic [ltc_pkg::WORD_W-1:0] cnt2_q, cnt2_d, rld_q, rld_d, cap1_q, cap1_d;
  logic rx_tick_q, rx_tick_d, tx_tick_q, tx_tick_d;

  // Write strobes decoded from the held address and data.
  logic wr_en;
  logic [ltc_pkg::IDX_W-1:0] rd_idx;

  assign wr_en = ~awready_q & ~wready_q & ~bvalid_q;
  assign rd_idx = i_s_axi_araddr[ltc_pkg::ADDR_W-1:ltc_pkg::IDX_LSB];

  function automatic logic lane(input logic [ltc_pkg::IDX_W-1:0] idx, input int ln);
    lane = wr_en && (widx_q == idx) && wstrb_q[ln];
  endfunction : lane

  function automatic logic [BW-1:0] wbyte(input int ln);
    wbyte = wdata_q[ln*BW +: BW];
  endfunction : wbyte

  function automatic logic mapped(input logic [ltc_pkg::IDX_W-1:0] idx);
    mapped = (idx >= ltc_pkg::IDX_T01_CTRL && idx <= ltc_pkg::IDX_T1_HIGH) ||
             (idx >= ltc_pkg::IDX_T2_CTRL && idx <= ltc_pkg::IDX_CAP1_HIGH);
  endfunction : mapped

  // One count step of timer 0 or 1; returns {overflow, high, low}.
  function automatic logic [2*BW:0] step(input ltc_pkg::ltc_mode_e m,
                                         input logic [BW-1:0] lo, input logic [BW-1:0] hi);
    logic [ltc_pkg::M0_W:0] s13;
    logic [2*BW:0] s16;
    logic [BW:0] s8;
    s13 = {1'b0, hi, lo[ltc_pkg::M0_LOW_W-1:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    step = {1'b0, hi, lo};
    unique case (m)
      ltc_pkg::MODE_13BIT: begin
        // The three upper low-byte bits stay out of the count.
        step = {s13[ltc_pkg::M0_W], s13[ltc_pkg::M0_W-1:ltc_pkg::M0_LOW_W],
                lo[BW-1:ltc_pkg::M0_LOW_W], s13[ltc_pkg::M0_LOW_W-1:0]};
      end
      ltc_pkg::MODE_16BIT: begin
        step = s16;
      end
      ltc_pkg::MODE_8RELOAD: begin
        step = s8[BW] ? {1'b1, hi, hi} : {1'b0, hi, s8[BW-1:0]};
      end
      ltc_pkg::MODE_SPLIT: begin
        step = {s8[BW], hi, s8[BW-1:0]};
      end
    endcase
  endfunction : step

  // Bus handshakes.
  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    widx_d = widx_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awready_q && i_s_axi_awvalid) begin
      awready_d = 1'b0;
      widx_d = i_s_axi_awaddr[ltc_pkg::ADDR_W-1:ltc_pkg::IDX_LSB];
    end
    if (wready_q && i_s_axi_wvalid) begin
      wready_d = 1'b0;
      wdata_d = i_s_axi_wdata;
      wstrb_d = i_s_axi_wstrb;
    end
    if (wr_en) begin
      bvalid_d = 1'b1;
      bresp_d = mapped(widx_q) ? ltc_pkg::RESP_OKAY : ltc_pkg::RESP_SLVERR;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (arready_q && i_s_axi_arvalid) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = mapped(rd_idx) ? ltc_pkg::RESP_OKAY : ltc_pkg::RESP_SLVERR;
      rdata_d = '0;
      unique case (rd_idx)
        ltc_pkg::IDX_T01_CTRL: begin
          rdata_d[ltc_pkg::T01C_OVF1] = ovf1_q;
          rdata_d[ltc_pkg::T01C_RUN1] = run1_q;
          rdata_d[ltc_pkg::T01C_OVF0] = ovf0_q;
          rdata_d[ltc_pkg::T01C_RUN0] = run0_q;
        end
        ltc_pkg::IDX_T01_MODE: rdata_d[BW-1:0] = {tmode1_q, tmode0_q};
        ltc_pkg::IDX_T0_LOW: rdata_d[BW-1:0] = lo0_q;
        ltc_pkg::IDX_T1_LOW: rdata_d[BW-1:0] = lo1_q;
        ltc_pkg::IDX_T0_HIGH: rdata_d[BW-1:0] = hi0_q;
        ltc_pkg::IDX_T1_HIGH: rdata_d[BW-1:0] = hi1_q;
        ltc_pkg::IDX_T2_CTRL: rdata_d[BW-1:0] = t2ctl_q;
        ltc_pkg::IDX_T2_MODE: rdata_d[ltc_pkg::T2M_CAP1_EN] = cap1_en_q;
        ltc_pkg::IDX_RELOAD_LOW: rdata_d[ltc_pkg::WORD_W-1:0] = rld_q;
        ltc_pkg::IDX_RELOAD_HIGH: rdata_d[BW-1:0] = rld_q[2*BW-1:BW];
        ltc_pkg::IDX_T2_COUNT_LOW: rdata_d[ltc_pkg::WORD_W-1:0] = cnt2_q;
        ltc_pkg::IDX_T2_COUNT_HIGH: rdata_d[BW-1:0] = cnt2_q[2*BW-1:BW];
        ltc_pkg::IDX_CAP1_LOW: rdata_d[ltc_pkg::WORD_W-1:0] = cap1_q;
        ltc_pkg::IDX_CAP1_HIGH: rdata_d[BW-1:0] = cap1_q[2*BW-1:BW];
        default: rdata_d = '0;
      endcase
    end
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  // Timers 0 and 1.
  logic gate0_ok, gate1_ok, tick0, tick1, tick0_high;
  logic [2*BW:0] s0, s1;
  logic t0_split;

  always_comb begin
    t0_split = (tmode0_q.mode == ltc_pkg::MODE_SPLIT);
    gate0_ok = ~tmode0_q.gate_enable | pin_level[ltc_pkg::PIN_INT0];
    gate1_ok = ~tmode1_q.gate_enable | pin_level[ltc_pkg::PIN_EXTERNAL_INTERRUPT_ONE_PIN];
    tick0 = run0_q & gate0_ok &
            (tmode0_q.counter_mode ? pin_fall[ltc_pkg::PIN_T0_COUNT] : 1'b1);
    // Timer 1 ignores its run bit while timer 0 is split, and halts in its own mode 3.
    tick1 = (t0_split | run1_q) & gate1_ok &
            (tmode1_q.mode != ltc_pkg::MODE_SPLIT) &
            (tmode1_q.counter_mode ? pin_fall[ltc_pkg::PIN_T1_COUNT] : 1'b1);
    tick0_high = t0_split & run1_q;
    s0 = step(tmode0_q.mode, lo0_q, hi0_q);
    s1 = step(tmode1_q.mode, lo1_q, hi1_q);
    run0_d = run0_q;
    run1_d = run1_q;
    tmode0_d = tmode0_q;
    tmode1_d = tmode1_q;
    lo0_d = lo0_q;
    hi0_d = hi0_q;
    lo1_d = lo1_q;
    hi1_d = hi1_q;
    ovf0_d = ovf0_q;
    ovf1_d = ovf1_q;
    if (lane(ltc_pkg::IDX_T01_CTRL, 0)) begin
      run0_d = wdata_q[ltc_pkg::T01C_RUN0];
      run1_d = wdata_q[ltc_pkg::T01C_RUN1];
      ovf0_d = wdata_q[ltc_pkg::T01C_OVF0];
      ovf1_d = wdata_q[ltc_pkg::T01C_OVF1];
    end
    if (lane(ltc_pkg::IDX_T01_MODE, 0)) begin
      {tmode1_d, tmode0_d} = wbyte(0);
    end
    if (tick0) begin
      lo0_d = s0[BW-1:0];
      if (!t0_split) begin
        hi0_d = s0[2*BW-1:BW];
      end
    end
    if (tick0_high) begin
      hi0_d = hi0_q + 8'h01;
    end
    if (tick1) begin
      {hi1_d, lo1_d} = s1[2*BW-1:0];
    end
    // Flag sets come after the software write so a set in the same cycle wins.
    ovf0_d = ovf0_d | (tick0 & s0[2*BW]);
    ovf1_d = ovf1_d | (tick0_high & (hi0_q == ltc_pkg::BYTE_ONES)) |
             (tick1 & s1[2*BW] & ~t0_split);
    if (lane(ltc_pkg::IDX_T0_LOW, 0)) lo0_d = wbyte(0);
    if (lane(ltc_pkg::IDX_T0_HIGH, 0)) hi0_d = wbyte(0);
    if (lane(ltc_pkg::IDX_T1_LOW, 0)) lo1_d = wbyte(0);
    if (lane(ltc_pkg::IDX_T1_HIGH, 0)) hi1_d = wbyte(0);
  end

  // Timer 2.
  logic tick2, ovf2, trig, cap1_edge, baud_mode, t1_ovf_pulse;

  always_comb begin
    t1_ovf_pulse = tick1 & s1[2*BW];
    baud_mode = t2ctl_q.uart_rx_baud_select | t2ctl_q.uart_tx_baud_select;
    tick2 = t2ctl_q.timer2_run &
            (t2ctl_q.timer2_clock_source ? pin_fall[ltc_pkg::PIN_T2_COUNT] : 1'b1);
    ovf2 = tick2 & (cnt2_q == {ltc_pkg::BYTE_ONES, ltc_pkg::BYTE_ONES});
    trig = t2ctl_q.external_trigger_enable & pin_fall[ltc_pkg::PIN_EXT_TRIG];
    cap1_edge = cap1_en_q & pin_fall[ltc_pkg::PIN_T2_COUNT];
    t2ctl_d = t2ctl_q;
    cap1_en_d = cap1_en_q;
    cnt2_d = cnt2_q;
    rld_d = rld_q;
    cap1_d = cap1_q;
    if (lane(ltc_pkg::IDX_T2_CTRL, 0)) t2ctl_d = wbyte(0);
    if (lane(ltc_pkg::IDX_T2_MODE, 0)) cap1_en_d = wdata_q[ltc_pkg::T2M_CAP1_EN];
    if (tick2) begin
      cnt2_d = cnt2_q + 16'h0001;
    end
    // Baud use overrides capture select, so overflow always reloads there.
    if (ovf2 && (!t2ctl_q.capture_reload_select || baud_mode)) begin
      cnt2_d = rld_q;
    end
    if (trig && !t2ctl_q.capture_reload_select) begin
      cnt2_d = rld_q;
    end
    if (trig && t2ctl_q.capture_reload_select) begin
      rld_d = cnt2_q;
    end
    if (cap1_edge) begin
      cap1_d = cnt2_q;
    end
    t2ctl_d.flag7 = t2ctl_d.flag7 |
                    (~cap1_en_q & ovf2 & ~baud_mode) |
                    cap1_edge;
    t2ctl_d.external_trigger_flag = t2ctl_d.external_trigger_flag | trig;
    if (lane(ltc_pkg::IDX_RELOAD_LOW, 0)) rld_d[BW-1:0] = wbyte(0);
    if (lane(ltc_pkg::IDX_RELOAD_LOW, 1)) rld_d[2*BW-1:BW] = wbyte(1);
    if (lane(ltc_pkg::IDX_RELOAD_HIGH, 0)) rld_d[2*BW-1:BW] = wbyte(0);
    if (lane(ltc_pkg::IDX_T2_COUNT_LOW, 0)) cnt2_d[BW-1:0] = wbyte(0);
    if (lane(ltc_pkg::IDX_T2_COUNT_LOW, 1)) cnt2_d[2*BW-1:BW] = wbyte(1);
    if (lane(ltc_pkg::IDX_T2_COUNT_HIGH, 0)) cnt2_d[2*BW-1:BW] = wbyte(0);
    rx_tick_d = t2ctl_q.uart_rx_baud_select ? ovf2 : t1_ovf_pulse;
    tx_tick_d = t2ctl_q.uart_tx_baud_select ? ovf2 : t1_ovf_pulse;
  end

  // Count bytes and capture one have no documented reset value; zero keeps outputs defined.
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= ltc_pkg::RESP_OKAY;
      widx_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= ltc_pkg::RESP_OKAY;
      rdata_q <= '0;
      tmode0_q <= ltc_pkg::TMODE_RESET;
      tmode1_q <= ltc_pkg::TMODE_RESET;
      run0_q <= 1'b0;
      run1_q <= 1'b0;
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
      lo0_q <= ltc_pkg::BYTE_RESET;
      hi0_q <= ltc_pkg::BYTE_RESET;
      lo1_q <= ltc_pkg::BYTE_RESET;
      hi1_q <= ltc_pkg::BYTE_RESET;
      t2ctl_q <= ltc_pkg::T2CTL_RESET;
      cap1_en_q <= 1'b0;
      cnt2_q <= ltc_pkg::WORD_RESET;
      rld_q <= ltc_pkg::WORD_RESET;
      cap1_q <= ltc_pkg::WORD_RESET;
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      widx_q <= widx_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      tmode0_q <= tmode0_d;
      tmode1_q <= tmode1_d;
      run0_q <= run0_d;
      run1_q <= run1_d;
      ovf0_q <= ovf0_d;
      ovf1_q <= ovf1_d;
      lo0_q <= lo0_d;
      hi0_q <= hi0_d;
      lo1_q <= lo1_d;
      hi1_q <= hi1_d;
      t2ctl_q <= t2ctl_d;
      cap1_en_q <= cap1_en_d;
      cnt2_q <= cnt2_d;
      rld_q <= rld_d;
      cap1_q <= cap1_d;
      rx_tick_q <= rx_tick_d;
      tx_tick_q <= tx_tick_d;
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready = wready_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_s_axi_rdata = rdata_q;
  assign O_UART_RX_BAUD_TICK = rx_tick_q;
  assign O_UART_TX_BAUD_TICK = tx_tick_q;

endmodule : ltc_top

// File: testbench/ltc_properties.sv
// Concurrent checks on the timer block's bus handshakes and baud ticks.
`timescale 1ns/1ps
module ltc_properties (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Register bus
  input wire logic [ltc_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [ltc_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [ltc_pkg::DATA_W-1:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Baud ticks
  input wire logic O_UART_RX_BAUD_TICK,
  input wire logic O_UART_TX_BAUD_TICK
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  logic wr_go;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  // Ticks are compared only after the source selection has settled for a while.
  always_comb begin
    wr_go = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    sel_d = sel_q;
    quiet_d = (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
    if (wr_go) begin
      quiet_d = 4'h0;
    end
    if (wr_go && i_s_axi_awaddr[11:2] == ltc_pkg::IDX_T2_CTRL) begin
      sel_d = i_s_axi_wdata[5:4];
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      sel_q <= 2'h0;
      quiet_q <= 4'h0;
    end else begin
      sel_q <= sel_d;
      quiet_q <= quiet_d;
    end
  end
  chk_wr_resp_time: assert property (disable iff (!I_RSTN)
    wr_go |-> ##1 !o_s_axi_bvalid ##1 o_s_axi_bvalid) else $error("write response timing");
  chk_wr_resp_hold: assert property (disable iff (!I_RSTN)
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  chk_wr_busy: assert property (disable iff (!I_RSTN)
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write taken early");
  chk_rd_resp_next: assert property (disable iff (!I_RSTN)
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read response late");
  chk_rd_data_hold: assert property (disable iff (!I_RSTN)
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data changed");
  chk_rd_busy: assert property (disable iff (!I_RSTN)
    o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken early");
  chk_reset_quiet: assert property (
    !I_RSTN |=> !o_s_axi_bvalid && !o_s_axi_rvalid && !O_UART_RX_BAUD_TICK)
    else $error("outputs active after reset");
  chk_baud_same_src: assert property (disable iff (!I_RSTN)
    quiet_q == 4'hf && sel_q[1] == sel_q[0] |-> O_UART_RX_BAUD_TICK == O_UART_TX_BAUD_TICK)
    else $error("baud ticks differ on one source");
endmodule : ltc_properties

// File: testbench/ltc_pin_model.sv
// External pin driver: idle high, low pulses and held low levels on request.
`timescale 1ns/1ps
module ltc_pin_model (
  // Clock
  input wire logic i_clk,
  // Requests
  input wire logic [5:0] i_fall,
  input wire logic [5:0] i_low,
  // Pins
  output logic [5:0] o_pins
);
  logic [2:0] cnt [6] = '{default: 3'h0};
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 6; k++) begin
      if (i_fall[k]) cnt[k] <= 3'h5;
      else if (cnt[k] != 3'h0) cnt[k] <= cnt[k] - 3'h1;
    end
  end
  // Pulses last five clocks so both synchroniser stages see them.
  always_comb begin
    for (int k = 0; k < 6; k++) o_pins[k] = !(cnt[k] != 3'h0 || i_low[k]);
  end
endmodule : ltc_pin_model

// File: testbench/ltc_tb_top.sv
// Self-checking bench for the legacy timer block with its pin partner.
`timescale 1ns/1ps
module legacy_timers_with_capture_tb_top;
  typedef struct packed {
    logic [9:0] idx;
    logic [15:0] wd;
    logic [3:0] st;
    logic [15:0] rd;
    logic [1:0] rs;
  } ltc_row_s;
  // Round trips; capture one is read-only and the last place is unmapped.
  ltc_row_s rows [9] = '{
    '{10'h08a, 16'h003c, 4'h1, 16'h003c, 2'h0}, '{10'h08b, 16'h00c3, 4'h1, 16'h00c3, 2'h0},
    '{10'h08c, 16'h005a, 4'h1, 16'h005a, 2'h0}, '{10'h08d, 16'h00a5, 4'h1, 16'h00a5, 2'h0},
    '{10'h089, 16'h00a5, 4'h1, 16'h00a5, 2'h0}, '{10'h0c9, 16'h00ff, 4'h1, 16'h0001, 2'h0},
    '{10'h0ca, 16'h1234, 4'h3, 16'h1234, 2'h0}, '{10'h0ce, 16'hffff, 4'h3, 16'h0000, 2'h0},
    '{10'h000, 16'hffff, 4'h1, 16'h0000, 2'h2}};
  // Timer 0 modes: mode, high, low, control, expected control.
  logic [7:0] tm [4][5] = '{'{8'h00, 8'hff, 8'h1f, 8'h10, 8'h30},
    '{8'h01, 8'hff, 8'hf0, 8'h10, 8'h30}, '{8'h02, 8'hf0, 8'hf0, 8'h10, 8'h30},
    '{8'h03, 8'hf0, 8'h00, 8'h40, 8'hc0}};
  logic I_CORE_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic [11:0] i_s_axi_awaddr = 12'h000;
  logic [11:0] i_s_axi_araddr = 12'h000;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'h0;
  logic i_s_axi_awvalid = 1'b0;
  logic i_s_axi_wvalid = 1'b0;
  logic i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0;
  logic i_s_axi_rready = 1'b0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rrs, bsv;
  logic [31:0] o_s_axi_rdata, rdv;
  logic O_UART_RX_BAUD_TICK, O_UART_TX_BAUD_TICK;
  logic [5:0] pin_fall = 6'h00;
  logic [5:0] pin_low = 6'h00;
  logic [5:0] pins;
  int fails = 0;
  int checks_done = 0;
  int rx_n = 0;
  int tx_n = 0;
  always #4 I_CORE_CLK = ~I_CORE_CLK;
  ltc_top i_dut (
    .I_CORE_CLK, .I_RSTN, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .I_TIMER0_COUNT_PIN(pins[0]), .I_TIMER1_COUNT_PIN(pins[1]),
    .I_EXTERNAL_INTERRUPT_ZERO_PIN(pins[2]), .I_EXTERNAL_INTERRUPT_ONE_PIN(pins[3]),
    .I_TIMER2_COUNT_PIN(pins[4]), .I_EXTERNAL_TRIGGER_PIN(pins[5]),
    .O_UART_RX_BAUD_TICK, .O_UART_TX_BAUD_TICK);
  ltc_pin_model i_pins (.i_clk(I_CORE_CLK), .i_fall(pin_fall), .i_low(pin_low), .o_pins(pins));
  always @(posedge I_CORE_CLK) begin
    if (O_UART_RX_BAUD_TICK === 1'b1) rx_n++;
    if (O_UART_TX_BAUD_TICK === 1'b1) tx_n++;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask : check
  task automatic wr(input logic [9:0] i, input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge I_CORE_CLK);
    i_s_axi_awaddr <= {i, 2'b00};
    i_s_axi_wdata <= {16'h0000, d};
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CORE_CLK);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid && i_s_axi_bready) break;
      if (o_s_axi_bvalid) i_s_axi_bready <= 1'b1;
    end
    i_s_axi_bready <= 1'b0;
    bsv = o_s_axi_bresp;
    if (n == 50) fails++;
  endtask : wr
  task automatic rd(input logic [9:0] i);
    int n;
    @(posedge I_CORE_CLK);
    i_s_axi_araddr <= {i, 2'b00};
    i_s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge I_CORE_CLK);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid && i_s_axi_rready) break;
      if (o_s_axi_rvalid) i_s_axi_rready <= 1'b1;
    end
    i_s_axi_rready <= 1'b0;
    rdv = o_s_axi_rdata;
    rrs = o_s_axi_rresp;
    if (n == 50) fails++;
  endtask : rd
  task automatic rc(input logic [9:0] i, input logic [15:0] e, input string nm);
    rd(i);
    check(nm, rdv, {16'h0000, e});
  endtask : rc
  task automatic fall(input int k);
    @(posedge I_CORE_CLK);
    pin_fall[k] <= 1'b1;
    @(posedge I_CORE_CLK);
    pin_fall[k] <= 1'b0;
    repeat (10) @(posedge I_CORE_CLK);
  endtask : fall
  initial begin
    repeat (20000) @(posedge I_CORE_CLK);
    fails++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge I_CORE_CLK);
    I_RSTN <= 1'b1;
    rc(10'h0c8, 16'h0000, "t2ctl_reset");
    rc(10'h0cc, 16'h0000, "timer2_count_word_reset");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd, rows[i].st);
      check("bresp", {30'h0, bsv}, {30'h0, rows[i].rs});
      rd(rows[i].idx);
      check("rdata", rdv, {16'h0000, rows[i].rd});
      check("rresp", {30'h0, rrs}, {30'h0, rows[i].rs});
    end
    rc(10'h0cb, 16'h0012, "reload_high");
    wr(10'h0c9, 16'h0000, 4'h1);
    wr(10'h0cc, 16'hfff0, 4'h3);
    wr(10'h0c8, 16'h0004, 4'h1);
    repeat (40) @(posedge I_CORE_CLK);
    rc(10'h0c8, 16'h0084, "t2_overflow");
    rc(10'h0cd, 16'h0012, "t2_reloaded");
    wr(10'h0c8, 16'h0000, 4'h1);
    wr(10'h0cc, 16'hfff0, 4'h3);
    repeat (20) @(posedge I_CORE_CLK);
    rc(10'h0cc, 16'hfff0, "t2_stopped");
    rx_n = 0;
    tx_n = 0;
    wr(10'h0c8, 16'h0034, 4'h1);
    repeat (60) @(posedge I_CORE_CLK);
    rc(10'h0c8, 16'h0034, "baud_no_flag");
    check("rx_ticks", rx_n, 1);
    check("tx_ticks", tx_n, 1);
    wr(10'h0c8, 16'h0008, 4'h1);
    wr(10'h0cc, 16'h0777, 4'h3);
    fall(5);
    rc(10'h0c8, 16'h0048, "trig_flag");
    rc(10'h0cc, 16'h1234, "trig_reload");
    wr(10'h0cc, 16'h0abc, 4'h3);
    wr(10'h0c8, 16'h0009, 4'h1);
    fall(5);
    rc(10'h0ca, 16'h0abc, "trig_capture");
    wr(10'h0c8, 16'h0000, 4'h1);
    fall(5);
    rc(10'h0c8, 16'h0000, "trig_ignored");
    wr(10'h0c9, 16'h0001, 4'h1);
    wr(10'h0cc, 16'h0456, 4'h3);
    fall(4);
    rc(10'h0c8, 16'h0080, "cap1_flag");
    rc(10'h0ce, 16'h0456, "cap1_word");
    for (int m = 0; m < 4; m++) begin
      wr(10'h088, 16'h0000, 4'h1);
      wr(10'h089, {8'h00, tm[m][0]}, 4'h1);
      wr(10'h08c, {8'h00, tm[m][1]}, 4'h1);
      wr(10'h08a, {8'h00, tm[m][2]}, 4'h1);
      wr(10'h088, {8'h00, tm[m][3]}, 4'h1);
      repeat (40) @(posedge I_CORE_CLK);
      rc(10'h088, {8'h00, tm[m][4]}, "t0_overflow");
      if (m == 2) rc(10'h08c, 16'h00f0, "t0_reload_kept");
    end
    wr(10'h088, 16'h0000, 4'h1);
    wr(10'h089, 16'h0030, 4'h1);
    wr(10'h08b, 16'h00fc, 4'h1);
    wr(10'h088, 16'h0040, 4'h1);
    repeat (20) @(posedge I_CORE_CLK);
    rc(10'h08b, 16'h00fc, "t1_split_stop");
    wr(10'h088, 16'h0000, 4'h1);
    wr(10'h089, 16'h0005, 4'h1);
    wr(10'h08a, 16'h0000, 4'h1);
    wr(10'h088, 16'h0010, 4'h1);
    fall(0);
    fall(0);
    fall(0);
    rc(10'h08a, 16'h0003, "t0_pin_count");
    wr(10'h088, 16'h0000, 4'h1);
    wr(10'h089, 16'h0029, 4'h1);
    wr(10'h08a, 16'h0000, 4'h1);
    pin_low <= 6'h04;
    wr(10'h088, 16'h0050, 4'h1);
    repeat (20) @(posedge I_CORE_CLK);
    rc(10'h08a, 16'h0000, "t0_gated");
    check("t1_baud_ticks", rx_n + tx_n, 4);
    I_RSTN <= 1'b0;
    repeat (6) @(posedge I_CORE_CLK);
    I_RSTN <= 1'b1;
    rc(10'h0cc, 16'h0000, "midrun_reset");
    summarize();
  end
endmodule : legacy_timers_with_capture_tb_top
bind ltc_top ltc_properties u_chk (
  .I_CORE_CLK, .I_RSTN, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata,
  .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready,
  .O_UART_RX_BAUD_TICK, .O_UART_TX_BAUD_TICK);
